// [dspc_map.svh]
// Register map, field positions and reset values of the doze/sleep control
// Behaviour
// (RULE1) Doze lets the CPU run one cycle, then idle the rest of each period.
// (RULE2) Peripheral cycle clocks keep running at full rate during doze.
// (RULE3) Doze throttles only CPU and flash; bandgap and oscillators stay on.
// (RULE4) Without fast-on-interrupt the service routine runs at the doze rate.
// (RULE5) With fast-on-interrupt an interrupt clears doze_active at once.
// (RULE6) An interrupt ending doze runs the prefetched instruction, then vectors.
// (RULE7) Return from interrupt with slow_on_return set sets doze_active.
// (RULE8) If the prefetched instruction clears global enable, skip vector, still speed up.
// (RULE9) Sleep instruction with idle_select clear enters full sleep.
// (RULE10) Sleep entry clears watchdog; watchdog may keep running; CPU clock stops.
// (RULE11) Sleep entry clears powerdown_flag and sets timeout_flag.
// (RULE12) Low-frequency, secondary, high-frequency and converter oscillators stay on in sleep.
// (RULE13) I/O ports hold their drive state during sleep.
// (RULE14) Sleep changes no reset source except the watchdog.
// (RULE15) Enabled pin, brown-out, low-power brown-out, power-on, watchdog wakes reset the device.
// (RULE16) Any interrupt except clock-switch wakes from sleep and continues execution.
// (RULE17) Wake needs own enable, plus peripheral enable outside first group; global ignored.
// (RULE18) After interrupt wake, next instruction runs; service routine follows if globally enabled.
// (RULE19) Watchdog is cleared on every wake from sleep.
// (RULE20) After wake, wait for flash ready, oscillator ready and brown-out ready.
// (RULE21) Interrupt pending before sleep with global disabled: sleep is a no-op.
// (RULE22) Interrupt during sleep entry: finish entry, wake at once, clear watchdog, set flags.
// (RULE23) Three-bit ratio field selects 1:2 at 000 up to 1:256 at 111.
// (RULE24) Sleep with idle_select set stops only the CPU clock.
// (RULE25) Doze skip counter restarts at its executing cycle when doze_active rises.
`ifndef DSPC_MAP_SVH
`define DSPC_MAP_SVH
`define DSPC_OFS_CTRL 12'h000
`define DSPC_OFS_STAT 12'h004
`define DSPC_OFS_SRCEN 12'h008
`define DSPC_CTRL_IDLE 7
`define DSPC_CTRL_DOZE 6
`define DSPC_CTRL_FAST 5
`define DSPC_CTRL_SLOW 4
`define DSPC_CTRL_RATIO_HI 2
`define DSPC_STAT_PD 0
`define DSPC_STAT_TO 1
`define DSPC_STAT_ST_LO 2
`define DSPC_STAT_WKIRQ 4
`define DSPC_STAT_WKRST 5
`define DSPC_CTRL_RST 8'h00
`define DSPC_SRCEN_RST 4'hF
`define DSPC_CNT_ZERO 8'h00
`define DSPC_CNT_ONE 8'h01
`endif

// [dspc_pkg.sv]
// Types shared by the doze/sleep control
package dspc_pkg;
  // Gray codes along run, sleep, wake; idle off the side
  typedef enum logic [1:0] {
    DSPC_RUN = 2'h0,
    DSPC_SLEEP = 2'h1,
    DSPC_WAKE = 2'h3,
    DSPC_IDLE = 2'h2
  } dspc_state_t;
endpackage : dspc_pkg

// [dspc_top.sv]
// Doze, idle and sleep power control with APB register access
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "dspc_map.svh"
module dspc_top (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU core events, same clock
  input wire logic sleep_exec,
  input wire logic irq_req,
  input wire logic prefetch_clears_gie,
  input wire logic return_from_irq,
  input wire logic global_irq_enable,
  // Wake sources, same clock, clock-switch excluded upstream
  input wire logic first_irq_flag_group,
  input wire logic other_irq_flag_group,
  input wire logic peripheral_irq_enable,
  input wire logic watchdog_timeout,
  input wire logic watchdog_sleep_enable,
  // Asynchronous reset sources from pins and analog
  input wire logic external_reset_pin_n,
  input wire logic brownout_reset,
  input wire logic low_power_brownout_reset,
  input wire logic power_on_event,
  // Readiness after wake
  input wire logic program_flash_ready,
  input wire logic osc_ready,
  input wire logic brownout_ready,
  input wire logic brownout_enable,
  // Clock and power controls
  output logic cpu_cycle_en,
  output logic periph_cycle_en,
  output logic cpu_clk_en,
  output logic sys_osc_en,
  output logic aux_osc_en,
  output logic io_hold,
  output logic watchdog_clear,
  output logic watchdog_run,
  output logic irq_vector_go,
  output logic device_reset_req
);

  // Last count of a doze period: 2^(ratio+1) minus one
  function automatic logic [7:0] dspc_last(input logic [2:0] ratio);
    dspc_last = 8'(9'h002 << ratio) - 8'h01; // [RULE23]
  endfunction : dspc_last

  logic [7:0] ctrl_r;
  logic [3:0] srcen_r;
  logic powerdown_flag_r;
  logic timeout_flag_r;
  logic wake_irq_r;
  logic wake_rst_r;
  dspc_pkg::dspc_state_t state_r;
  dspc_pkg::dspc_state_t state_nxt;
  logic [7:0] cnt_r;
  logic doze_prev_r;
  logic vec_pend_r;
  logic vec_skip_r;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] sync3_r;
  logic [3:0] src_r;

  wire doze_active = ctrl_r[`DSPC_CTRL_DOZE];
  wire idle_select = ctrl_r[`DSPC_CTRL_IDLE];
  wire fast_on_interrupt = ctrl_r[`DSPC_CTRL_FAST];
  wire slow_on_return = ctrl_r[`DSPC_CTRL_SLOW];
  wire [2:0] ratio = ctrl_r[`DSPC_CTRL_RATIO_HI:0];
  wire wr_acc = psel & penable & pwrite & pready;
  wire setup = psel & ~penable;

  // Wake interrupt: global enable deliberately ignored
  wire irq_wake = first_irq_flag_group
    | (other_irq_flag_group & peripheral_irq_enable); // [RULE17] [RULE16]

  // Enabled reset sources; same set whatever the sleep state
  wire rst_any = (src_r[0] & srcen_r[0]) | (src_r[1] & srcen_r[1])
    | (src_r[2] & srcen_r[2]) | src_r[3]
    | (watchdog_timeout & watchdog_sleep_enable); // [RULE14] [RULE15]

  wire ready_all = program_flash_ready & osc_ready
    & (brownout_ready | ~brownout_enable); // [RULE20]

  wire sleep_nop = sleep_exec & irq_wake & ~global_irq_enable; // [RULE21]
  wire sleep_go = (state_r == dspc_pkg::DSPC_RUN) & sleep_exec & ~sleep_nop;
  wire sleep_full = sleep_go & ~idle_select; // [RULE9]
  wire in_sleep = (state_r == dspc_pkg::DSPC_SLEEP)
    | (state_r == dspc_pkg::DSPC_IDLE);
  wire wake_now = in_sleep & (irq_wake | rst_any);

  // Three-stage capture of pin-domain sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
    end else begin
      sync1_r <= {power_on_event, low_power_brownout_reset,
                  brownout_reset, ~external_reset_pin_n};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_r <= 4'h0;
    end else begin
      src_r <= (sync2_r & sync3_r) | (src_r & (sync2_r | sync3_r));
    end
  end

  // Power state sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dspc_pkg::DSPC_RUN: begin
        if (sleep_go) begin
          state_nxt = idle_select ? dspc_pkg::DSPC_IDLE
                                  : dspc_pkg::DSPC_SLEEP; // [RULE24]
        end
      end
      dspc_pkg::DSPC_SLEEP: begin
        if (wake_now) begin
          state_nxt = dspc_pkg::DSPC_WAKE; // [RULE22]
        end
      end
      dspc_pkg::DSPC_IDLE: begin
        if (wake_now) begin
          state_nxt = dspc_pkg::DSPC_WAKE;
        end
      end
      dspc_pkg::DSPC_WAKE: begin
        if (ready_all) begin
          state_nxt = dspc_pkg::DSPC_RUN; // [RULE20]
        end
      end
      default: state_nxt = dspc_pkg::DSPC_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= dspc_pkg::DSPC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Control register; hardware set/clear beats a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `DSPC_CTRL_RST;
    end else begin
      if (wr_acc && paddr == `DSPC_OFS_CTRL) begin
        ctrl_r <= pwdata[7:0];
      end
      if (irq_req && fast_on_interrupt) begin
        ctrl_r[`DSPC_CTRL_DOZE] <= 1'b0; // [RULE5] [RULE8]
      end else if (return_from_irq && slow_on_return) begin
        ctrl_r[`DSPC_CTRL_DOZE] <= 1'b1; // [RULE7]
      end
    end
  end

  // Enables for pin, brown-out, low-power brown-out resets; bit 3 is stored but unused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srcen_r <= `DSPC_SRCEN_RST;
    end else if (wr_acc && paddr == `DSPC_OFS_SRCEN) begin
      srcen_r <= pwdata[3:0];
    end
  end

  // Status flags; full sleep entry wins over a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerdown_flag_r <= 1'b1;
      timeout_flag_r <= 1'b1;
    end else if (sleep_full) begin
      powerdown_flag_r <= 1'b0; // [RULE11] [RULE22]
      timeout_flag_r <= 1'b1; // [RULE11]
    end else if (wr_acc && paddr == `DSPC_OFS_STAT) begin
      powerdown_flag_r <= pwdata[`DSPC_STAT_PD];
      timeout_flag_r <= pwdata[`DSPC_STAT_TO];
    end
  end

  // Cause of the last wake, cleared on the next sleep entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_irq_r <= 1'b0;
      wake_rst_r <= 1'b0;
    end else if (sleep_go) begin
      wake_irq_r <= 1'b0;
      wake_rst_r <= 1'b0;
    end else if (wake_now) begin
      wake_irq_r <= ~rst_any; // [RULE16]
      wake_rst_r <= rst_any; // [RULE15]
    end
  end

  // Doze skip counter; count zero is the executing cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= `DSPC_CNT_ZERO;
      doze_prev_r <= 1'b0;
    end else begin
      doze_prev_r <= doze_active;
      // Rise cycle is the executing slot, so count on from one
      if (doze_active && !doze_prev_r) begin
        cnt_r <= `DSPC_CNT_ONE; // [RULE25]
      end else if (cnt_r >= dspc_last(ratio)) begin
        cnt_r <= `DSPC_CNT_ZERO; // [RULE1]
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  // In the run state, one CPU cycle per period in doze, every cycle otherwise
  wire cpu_slot = (state_r == dspc_pkg::DSPC_RUN)
    & (~doze_active | (doze_prev_r & cnt_r == `DSPC_CNT_ZERO)
       | (doze_active & ~doze_prev_r)); // [RULE1] [RULE4]

  // Interrupt vectoring waits for one prefetched instruction slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_pend_r <= 1'b0;
      vec_skip_r <= 1'b0;
    end else if (irq_req) begin
      vec_pend_r <= 1'b1; // [RULE6]
      vec_skip_r <= prefetch_clears_gie; // [RULE8]
    end else if (state_r == dspc_pkg::DSPC_WAKE && ready_all
                 && wake_irq_r) begin
      vec_pend_r <= 1'b1; // [RULE18]
      vec_skip_r <= ~global_irq_enable; // [RULE18]
    end else if (vec_pend_r && cpu_slot) begin
      vec_pend_r <= 1'b0;
      vec_skip_r <= 1'b0;
    end
  end

  // Registered clock and power outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_cycle_en <= 1'b0;
      periph_cycle_en <= 1'b0;
      cpu_clk_en <= 1'b0;
      sys_osc_en <= 1'b0;
      aux_osc_en <= 1'b0;
      io_hold <= 1'b0;
      watchdog_run <= 1'b0;
    end else begin
      cpu_cycle_en <= cpu_slot; // [RULE1] [RULE3]
      periph_cycle_en <= state_r != dspc_pkg::DSPC_SLEEP; // [RULE2] [RULE24]
      cpu_clk_en <= state_r == dspc_pkg::DSPC_RUN
        || state_r == dspc_pkg::DSPC_WAKE; // [RULE10]
      sys_osc_en <= state_r != dspc_pkg::DSPC_SLEEP; // [RULE3]
      aux_osc_en <= 1'b1; // [RULE12]
      io_hold <= in_sleep; // [RULE13]
      watchdog_run <= ~in_sleep | watchdog_sleep_enable; // [RULE10]
    end
  end

  // One-cycle event outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_clear <= 1'b0;
      irq_vector_go <= 1'b0;
      device_reset_req <= 1'b0;
    end else begin
      watchdog_clear <= sleep_full | wake_now; // [RULE10] [RULE19]
      irq_vector_go <= vec_pend_r & cpu_slot & ~vec_skip_r; // [RULE6]
      device_reset_req <= rst_any & ~device_reset_req; // [RULE15]
    end
  end

  // APB: one wait-free access phase, read data loaded at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && paddr != `DSPC_OFS_CTRL
        && paddr != `DSPC_OFS_STAT && paddr != `DSPC_OFS_SRCEN;
      if (setup) begin
        case (paddr)
          `DSPC_OFS_CTRL: prdata <= {24'h000000, ctrl_r};
          `DSPC_OFS_STAT: prdata <= {26'h0000000, wake_rst_r, wake_irq_r,
                                     state_r, timeout_flag_r,
                                     powerdown_flag_r};
          `DSPC_OFS_SRCEN: prdata <= {28'h0000000, srcen_r};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Checks
  sequence s_full_sleep;
    sleep_full;
  endsequence
  sequence s_flags_set;
    !powerdown_flag_r && timeout_flag_r;
  endsequence

  AST_SLEEP_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    s_full_sleep |=> s_flags_set) else $error("sleep flags wrong"); // [RULE11]
  AST_SLEEP_STATE: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_go && !idle_select |=> state_r == dspc_pkg::DSPC_SLEEP)
    else $error("no sleep"); // [RULE9]
  AST_NOP_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == dspc_pkg::DSPC_RUN) && sleep_nop
    |=> state_r == dspc_pkg::DSPC_RUN && $stable(timeout_flag_r)
    && !watchdog_clear) else $error("sleep not a no-op"); // [RULE21]
  AST_FAST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req && fast_on_interrupt |=> !doze_active)
    else $error("doze not cleared"); // [RULE5]
  AST_SLOW_RET: assert property (@(posedge pclk) disable iff (!presetn)
    return_from_irq && slow_on_return && !irq_req |=> doze_active)
    else $error("doze not set"); // [RULE7]
  AST_WAKE_WDT: assert property (@(posedge pclk) disable iff (!presetn)
    wake_now |=> watchdog_clear) else $error("no wdt clear"); // [RULE19]
  AST_WAKE_READY: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == dspc_pkg::DSPC_WAKE && !ready_all
    |=> state_r == dspc_pkg::DSPC_WAKE) else $error("early run"); // [RULE20]
  AST_DOZE_1IN4: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_slot && doze_active && doze_prev_r && ratio == 3'h1
    && state_r == dspc_pkg::DSPC_RUN && $stable(ctrl_r)
    ##1 $stable(ctrl_r) ##1 $stable(ctrl_r) ##1 $stable(ctrl_r)
    && state_r == dspc_pkg::DSPC_RUN |=> cpu_slot && !$past(cpu_slot))
    else $error("doze ratio wrong"); // [RULE1]
  AST_IDLE_PERIPH: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == dspc_pkg::DSPC_IDLE |=> periph_cycle_en && !cpu_clk_en)
    else $error("idle clocks wrong"); // [RULE24]
  AST_VECTOR_AFTER: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req && !prefetch_clears_gie && !doze_active ##1 !irq_req
    |=> irq_vector_go) else $error("vector missing"); // [RULE6]

endmodule : dspc_top

// [dspc_ready_model.sv]
// Readiness model of flash, oscillator and brown-out after a wake
`timescale 1ns/1ps
module dspc_ready_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Device state and pacing
  input wire logic sys_osc_en,
  input wire logic io_hold,
  input wire logic slow,
  // Readiness levels
  output logic program_flash_ready,
  output logic osc_ready,
  output logic brownout_ready
);
  logic [3:0] wait_r;

  // Halting drops flash readiness, and all three when slow; slow pacing stretches the settle time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 4'h0;
    end else if (!sys_osc_en || io_hold) begin
      wait_r <= slow ? 4'h8 : 4'h1;
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end
  end

  // Staggered so the last of the three gates the core
  assign program_flash_ready = wait_r == 4'h0;
  assign osc_ready = wait_r < 4'h2;
  assign brownout_ready = wait_r < 4'h4;
endmodule : dspc_ready_model

// [tb_top.sv]
// Self-checking bench for the doze, idle and sleep control
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
  bad_count++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [4:0] rsrc;
  logic [5:0] pwr;
  logic sleep_exec, irq_req, prefetch_clears_gie, return_from_irq;
  logic global_irq_enable, first_irq_flag_group, other_irq_flag_group;
  logic peripheral_irq_enable, watchdog_sleep_enable, program_flash_ready;
  logic osc_ready, brownout_ready, cpu_cycle_en, periph_cycle_en;
  logic cpu_clk_en, sys_osc_en, aux_osc_en, io_hold, watchdog_clear;
  logic watchdog_run, irq_vector_go, device_reset_req;
  int bad_count, compares, vec_n, wdc_n, rst_n, k;

  dspc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sleep_exec, .irq_req,
    .prefetch_clears_gie, .return_from_irq, .global_irq_enable,
    .first_irq_flag_group, .other_irq_flag_group, .peripheral_irq_enable,
    .watchdog_timeout(rsrc[4]), .watchdog_sleep_enable,
    .external_reset_pin_n(~rsrc[0]), .brownout_reset(rsrc[1]),
    .low_power_brownout_reset(rsrc[2]), .power_on_event(rsrc[3]),
    .program_flash_ready, .osc_ready, .brownout_ready,
    .brownout_enable(1'b1), .cpu_cycle_en, .periph_cycle_en, .cpu_clk_en,
    .sys_osc_en, .aux_osc_en, .io_hold, .watchdog_clear, .watchdog_run,
    .irq_vector_go, .device_reset_req);

  dspc_ready_model rdy (.pclk, .presetn, .sys_osc_en, .io_hold, .slow,
    .program_flash_ready, .osc_ready, .brownout_ready);

  // Power outputs gathered for one-shot comparison
  assign pwr = {cpu_clk_en, periph_cycle_en, sys_osc_en, aux_osc_en,
    io_hold, watchdog_run};

  // Event pulses counted on the falling edge, where they are settled
  always @(negedge pclk) begin
    vec_n += (irq_vector_go === 1'b1);
    wdc_n += (watchdog_clear === 1'b1);
    rst_n += (device_reset_req === 1'b1);
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
    end
    rq = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask : apb

  task automatic slp;
    sleep_exec <= 1'b1;
    @(posedge pclk);
    sleep_exec <= 1'b0;
  endtask : slp

  task automatic wait_cpu(input int lim);
    k = 0;
    while (cpu_cycle_en !== 1'b1 && k < lim) begin
      @(posedge pclk);
      k++;
    end
  endtask : wait_cpu

  task automatic t_regs;
    apb(1'h0, 12'h000, 32'h0);
    `CHK(rq, 32'h0)
    apb(1'h0, 12'h004, 32'h0);
    `CHK(rq, 32'h3)
    apb(1'h0, 12'h008, 32'h0);
    `CHK(rq, 32'hF)
    apb(1'h0, 12'h00C, 32'h0);
    `CHK({err, rq}, 33'h100000000)
  endtask : t_regs

  // Every ratio code; count windows span whole periods
  task automatic t_doze;
    int p, c, q;
    for (int r = 0; r < 8; r++) begin
      p = 2 << r;
      apb(1'h1, 12'h000, 32'h0);
      apb(1'h1, 12'h000, 32'h40 | r);
      cyc(p);
      c = 0;
      q = 0;
      repeat (2 * p) begin
        @(posedge pclk);
        c += (cpu_cycle_en === 1'b1);
        q += (periph_cycle_en === 1'b1 && sys_osc_en === 1'b1);
      end
      `CHK(c, 2)
      `CHK(q, 2 * p)
    end
  endtask : t_doze

  task automatic t_irq(input logic [31:0] c, input logic g,
      input logic de, input int ve);
    int n;
    apb(1'h1, 12'h000, c);
    n = vec_n;
    irq_req <= 1'b1;
    prefetch_clears_gie <= g;
    @(posedge pclk);
    irq_req <= 1'b0;
    cyc(40);
    apb(1'h0, 12'h000, 32'h0);
    `CHK(rq[6], de)
    `CHK(vec_n - n, ve)
  endtask : t_irq

  task automatic t_ints;
    global_irq_enable <= 1'b1;
    t_irq(32'h63, 1'b0, 1'b0, 1);
    k = 0;
    repeat (8) begin
      @(posedge pclk);
      k += (cpu_cycle_en === 1'b1);
    end
    `CHK(k, 8)
    t_irq(32'h63, 1'b1, 1'b0, 0);
    t_irq(32'h43, 1'b0, 1'b1, 1);
    t_irq(32'h0, 1'b0, 1'b0, 1);
    apb(1'h1, 12'h000, 32'h13);
    return_from_irq <= 1'b1;
    @(posedge pclk);
    return_from_irq <= 1'b0;
    cyc(2);
    apb(1'h0, 12'h000, 32'h0);
    `CHK(rq[7:0], 8'h53)
    apb(1'h1, 12'h000, 32'h0);
  endtask : t_ints

  // Full sleep, peripheral-group wake with slow readiness
  task automatic t_sleep;
    int w, n;
    w = wdc_n;
    slow <= 1'b1;
    slp();
    cyc(3);
    `CHK(pwr, 6'h07)
    `CHK(wdc_n - w, 1)
    apb(1'h0, 12'h004, 32'h0);
    `CHK(rq[3:0], 4'h6)
    other_irq_flag_group <= 1'b1;
    cyc(6);
    `CHK(io_hold, 1'b1)
    n = vec_n;
    peripheral_irq_enable <= 1'b1;
    cyc(3);
    `CHK(cpu_cycle_en, 1'b0)
    wait_cpu(30);
    `CHK(k < 30, 1'b1)
    cyc(4);
    `CHK(vec_n - n, 1)
    `CHK(wdc_n - w, 2)
    other_irq_flag_group <= 1'b0;
    peripheral_irq_enable <= 1'b0;
  endtask : t_sleep

  // Pending before sleep is a no-op; flagged during entry wakes at once
  task automatic t_noop;
    int w, n;
    global_irq_enable <= 1'b0;
    slow <= 1'b0;
    apb(1'h1, 12'h004, 32'h3);
    w = wdc_n;
    first_irq_flag_group <= 1'b1;
    @(posedge pclk);
    slp();
    cyc(3);
    apb(1'h0, 12'h004, 32'h0);
    `CHK(rq[3:0], 4'h3)
    `CHK(wdc_n - w, 0)
    first_irq_flag_group <= 1'b0;
    n = vec_n;
    cyc(2);
    slp();
    first_irq_flag_group <= 1'b1;
    cyc(12);
    apb(1'h0, 12'h004, 32'h0);
    `CHK(rq[3:0], 4'h2)
    `CHK(wdc_n - w, 2)
    `CHK(vec_n - n, 0)
    first_irq_flag_group <= 1'b0;
  endtask : t_noop

  task automatic t_idle;
    apb(1'h1, 12'h000, 32'h80);
    slp();
    cyc(3);
    `CHK(pwr, 6'h1F)
    apb(1'h0, 12'h004, 32'h0);
    `CHK(rq[3:2], 2'h2)
    first_irq_flag_group <= 1'b1;
    cyc(2);
    wait_cpu(30);
    `CHK(pwr, 6'h3D)
    first_irq_flag_group <= 1'b0;
    apb(1'h1, 12'h000, 32'h0);
  endtask : t_idle

  // Pulse one reset source with its enable set or cleared
  task automatic rst_src(input int i, input logic en);
    int n;
    apb(1'h1, 12'h008, 32'hF ^ (en ? 32'h0 : 32'h1 << i));
    n = rst_n;
    rsrc <= 5'h1 << i;
    cyc(8);
    rsrc <= 5'h0;
    cyc(8);
    `CHK(rst_n > n, en)
  endtask : rst_src

  task automatic end_of_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, rsrc} = '0;
    {sleep_exec, irq_req, prefetch_clears_gie, return_from_irq} = '0;
    {global_irq_enable, first_irq_flag_group, other_irq_flag_group} = '0;
    {peripheral_irq_enable, slow} = '0;
    watchdog_sleep_enable = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_doze();
    t_ints();
    t_sleep();
    t_noop();
    t_idle();
    for (int i = 0; i < 5; i++) begin
      if (i < 3) begin
        rst_src(i, 1'b0);
      end
      rst_src(i, 1'b1);
    end
    end_of_test();
  end

  // Watchdog well beyond the few thousand cycles the run needs
  initial begin
    #1000000;
    bad_count++;
    end_of_test();
  end
endmodule : tb_top
